// ==== hdl/pcd_pkg.sv ====
// package: register map, field layout, reset values and timing for the clock control block
`default_nettype none
package pcd_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CTL    = 4'h0;
  localparam logic [3:0] ADDR_DIV    = 4'h4;
  localparam logic [3:0] ADDR_LOCK   = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // pll_control_register fields
  localparam int CTL_MULT_LSB = 0;
  localparam int CTL_MULT_MSB = 7;
  localparam int CTL_BYPASS   = 8;
  localparam int CTL_VOLT     = 9;

  // divider register fields
  localparam int DIV_SYS_LSB  = 0;
  localparam int DIV_SYS_MSB  = 3;
  localparam int DIV_CORE_LSB = 4;
  localparam int DIV_CORE_MSB = 5;

  // status register fields
  localparam int STS_LOCKED   = 0;
  localparam int STS_BUSY     = 1;
  localparam int STS_MULT_LSB = 8;
  localparam int STS_MULT_MSB = 15;
  localparam int STS_REM_LSB  = 16;
  localparam int STS_REM_MSB  = 31;

  // multiplier held in half steps: code 1 is 0.5x, code 128 is 64x
  localparam logic [7:0]  MULT_MIN    = 8'h01;
  localparam logic [7:0]  MULT_MAX    = 8'h80;
  localparam logic [7:0]  MULT_RESET  = 8'h14;
  localparam logic [3:0]  SYS_RESET   = 4'h5;
  localparam logic [3:0]  SYS_MIN     = 4'h1;
  localparam logic [1:0]  CORE_RESET  = 2'h0;
  localparam logic [3:0]  RATIO_ONE   = 4'h1;
  localparam logic [15:0] LOCK_RESET  = 16'h0200;

  // longest settle time, and its cycle count at the input clock rate
  localparam int SETTLE_TIME_US = 40;
  localparam int CLK_FREQ_MHZ   = 10;
  localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b01,
    ST_RELOCK = 2'b10
  } pcd_fsm_type;

  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcd_bus_type;
endpackage
`default_nettype wire

// ==== hdl/pcd_divider.sv ====
// programmable divider: one output pulse per ratio source ticks
`default_nettype none
module pcd_divider #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] ratio,
  output logic                  pulse
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             pulse;
  } pcd_div_state_type;

  pcd_div_state_type state;
  pcd_div_state_type next_state;

  // ratio is read every tick, so a new value acts at once
  always_comb
  begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (tick)
    begin
      if (state.cnt + WIDTH'(1) >= ratio)
      begin
        next_state.cnt = '0;
        next_state.pulse = 1'b1;
      end
      else
        next_state.cnt = state.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign pulse = state.pulse;
endmodule
`default_nettype wire

// ==== hdl/pcd_lock_counter.sv ====
// lock counter: counts input clock periods down after a start, capped at the settle limit
`default_nettype none
module pcd_lock_counter (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [15:0] load,
  output logic             busy,
  output logic [15:0]      remain
);
  localparam logic [15:0] SETTLE_LAST = 16'(pcd_pkg::SETTLE_CYCLES - 1);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] elapsed;
    logic        busy;
  } pcd_lock_state_type;

  pcd_lock_state_type state;
  pcd_lock_state_type next_state;

  // ends on the programmed count or the settle limit, whichever comes first
  always_comb
  begin
    next_state = state;
    if (start)
    begin
      next_state.cnt = load;
      next_state.elapsed = '0;
      next_state.busy = (load != '0);
    end
    else if (state.busy)
    begin
      next_state.cnt = state.cnt - 16'h0001;
      next_state.elapsed = state.elapsed + 16'h0001;
      if (state.cnt == 16'h0001 || state.elapsed == SETTLE_LAST)
        next_state.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign busy = state.busy;
  assign remain = state.cnt;
endmodule
`default_nettype wire

// ==== hdl/pcd_clock_control.sv ====
// clock control: multiplier, core and system dividers, lock counting and registers
`default_nettype none
module pcd_clock_control (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        VCO_TICK,
  output logic             CORE_CLK_EN,
  output logic             SYS_CLK_EN,
  output logic             PERIPH_CLK_EN,
  output logic      [7:0]  PLL_MULT,
  output logic             PLL_BYPASS,
  output logic             VOLT_CHANGE,
  output logic             LOCKED
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pcd_pkg::pcd_fsm_type fsm;
    logic [7:0]           mult_pend;
    logic [7:0]           mult_applied;
    logic                 bypass;
    logic [3:0]           sys_sel;
    logic [1:0]           core_sel;
    logic [15:0]          lock_count;
    logic                 volt_req;
    logic                 volt_start;
    logic                 start;
    logic                 vco_meta;
    logic                 vco_sync;
    logic [31:0]          rdata;
  } pcd_top_state_type;

  pcd_top_state_type  state;
  pcd_top_state_type  next_state;
  pcd_pkg::pcd_bus_type bus;
  logic               lock_busy;
  logic [15:0]        lock_remain;
  logic               sys_pulse;
  logic               core_pulse;
  logic               src_tick;
  logic [3:0]         sys_ratio;
  logic [3:0]         core_ratio;

  // decode of the two-bit core select into its divide ratio
  function automatic logic [3:0] core_decode(input logic [1:0] sel);
    core_decode = 4'(pcd_pkg::RATIO_ONE << sel);
  endfunction

  function automatic logic mult_ok(input logic [7:0] m);
    mult_ok = (m >= pcd_pkg::MULT_MIN) && (m <= pcd_pkg::MULT_MAX);
  endfunction

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  //////////////////////////////////////////////////////////////////////////////
  // clock source for the dividers: the input clock itself when bypassed or
  // relocking, so an unsettled pll never reaches the core or peripherals
  always_comb
  begin
    if (state.bypass || state.fsm != pcd_pkg::ST_RUN)
    begin
      src_tick   = 1'b1;
      sys_ratio  = pcd_pkg::RATIO_ONE;
      core_ratio = pcd_pkg::RATIO_ONE;
    end
    else
    begin
      src_tick   = state.vco_sync;
      sys_ratio  = state.sys_sel;
      core_ratio = core_decode(state.core_sel);
    end
  end

  pcd_divider #(.WIDTH(4)) u_sys_div (
    .clk   (CLK),
    .rst_n (RST_N),
    .tick  (src_tick),
    .ratio (sys_ratio),
    .pulse (sys_pulse)
  );

  pcd_divider #(.WIDTH(4)) u_core_div (
    .clk   (CLK),
    .rst_n (RST_N),
    .tick  (src_tick),
    .ratio (core_ratio),
    .pulse (core_pulse)
  );

  pcd_lock_counter u_lock (
    .clk    (CLK),
    .rst_n  (RST_N),
    .start  (state.start),
    .load   (state.lock_count),
    .busy   (lock_busy),
    .remain (lock_remain)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register writes, read mux, relock sequencing
  always_comb
  begin
    next_state = state;
    next_state.start = 1'b0;
    next_state.volt_start = 1'b0;
    next_state.rdata = '0;
    // pll tick pin is asynchronous: two flops before use
    next_state.vco_meta = VCO_TICK;
    next_state.vco_sync = state.vco_meta;

    // relock sequencing
    case (state.fsm)
      pcd_pkg::ST_RUN:
      begin
        if (!state.bypass && (state.mult_pend != state.mult_applied || state.volt_req))
        begin
          next_state.mult_applied = state.mult_pend;
          next_state.start = 1'b1;
          next_state.volt_start = state.volt_req;
          next_state.volt_req = 1'b0;
          next_state.fsm = pcd_pkg::ST_RELOCK;
        end
      end
      pcd_pkg::ST_RELOCK:
      begin
        if (!state.start && !lock_busy)
          next_state.fsm = pcd_pkg::ST_RUN;
      end
      default:
        next_state.fsm = pcd_pkg::ST_RUN;
    endcase

    // writes; a new voltage request wins over its own consumption
    if (bus.wr)
    begin
      case (bus.addr)
        pcd_pkg::ADDR_CTL:
        begin
          if (mult_ok(bus.wdata[pcd_pkg::CTL_MULT_MSB:pcd_pkg::CTL_MULT_LSB]))
            next_state.mult_pend = bus.wdata[pcd_pkg::CTL_MULT_MSB:pcd_pkg::CTL_MULT_LSB];
          next_state.bypass = bus.wdata[pcd_pkg::CTL_BYPASS];
          if (bus.wdata[pcd_pkg::CTL_VOLT])
            next_state.volt_req = 1'b1;
        end
        pcd_pkg::ADDR_DIV:
        begin
          if (bus.wdata[pcd_pkg::DIV_SYS_MSB:pcd_pkg::DIV_SYS_LSB] >= pcd_pkg::SYS_MIN)
            next_state.sys_sel = bus.wdata[pcd_pkg::DIV_SYS_MSB:pcd_pkg::DIV_SYS_LSB];
          next_state.core_sel = bus.wdata[pcd_pkg::DIV_CORE_MSB:pcd_pkg::DIV_CORE_LSB];
        end
        pcd_pkg::ADDR_LOCK:
          next_state.lock_count = bus.wdata[15:0];
        default:
          next_state.lock_count = state.lock_count;           // unmapped writes are dropped
      endcase
    end

    // reads: data stand in the following cycle only
    if (bus.rd)
    begin
      case (bus.addr)
        pcd_pkg::ADDR_CTL:
        begin
          next_state.rdata[pcd_pkg::CTL_MULT_MSB:pcd_pkg::CTL_MULT_LSB] = state.mult_pend;
          next_state.rdata[pcd_pkg::CTL_BYPASS] = state.bypass;
          next_state.rdata[pcd_pkg::CTL_VOLT] = state.volt_req;
        end
        pcd_pkg::ADDR_DIV:
        begin
          next_state.rdata[pcd_pkg::DIV_SYS_MSB:pcd_pkg::DIV_SYS_LSB] = state.sys_sel;
          next_state.rdata[pcd_pkg::DIV_CORE_MSB:pcd_pkg::DIV_CORE_LSB] = state.core_sel;
        end
        pcd_pkg::ADDR_LOCK:
          next_state.rdata[15:0] = state.lock_count;
        pcd_pkg::ADDR_STATUS:
        begin
          next_state.rdata[pcd_pkg::STS_LOCKED] = (state.fsm == pcd_pkg::ST_RUN);
          next_state.rdata[pcd_pkg::STS_BUSY] = lock_busy;
          next_state.rdata[pcd_pkg::STS_MULT_MSB:pcd_pkg::STS_MULT_LSB] = state.mult_applied;
          next_state.rdata[pcd_pkg::STS_REM_MSB:pcd_pkg::STS_REM_LSB] = lock_remain;
        end
        default:
          next_state.rdata = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; reset values are constants only
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= '0;
      state.fsm <= pcd_pkg::ST_RUN;
      state.mult_pend <= pcd_pkg::MULT_RESET;
      state.mult_applied <= pcd_pkg::MULT_RESET;
      state.sys_sel <= pcd_pkg::SYS_RESET;
      state.core_sel <= pcd_pkg::CORE_RESET;
      state.lock_count <= pcd_pkg::LOCK_RESET;
    end
    else
      state <= next_state;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign RDATA         = state.rdata;
  assign CORE_CLK_EN   = core_pulse;
  assign SYS_CLK_EN    = sys_pulse;
  assign PERIPH_CLK_EN = sys_pulse;
  assign PLL_MULT      = state.mult_applied;
  assign PLL_BYPASS    = state.bypass;
  assign VOLT_CHANGE   = state.volt_start;
  assign LOCKED        = (state.fsm == pcd_pkg::ST_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // settle limit plus the start cycle and the state update back to run
  localparam int SETTLE_BOUND = pcd_pkg::SETTLE_CYCLES + 2;

  sequence s_relock_start;
    state.fsm == pcd_pkg::ST_RUN ##1 state.start;
  endsequence

  sequence s_relock_end;
    ##[1:SETTLE_BOUND] LOCKED;
  endsequence

  a_mult_range: assert property (mult_ok(state.mult_pend) && mult_ok(state.mult_applied))
    else $error("multiplier out of range");

  a_sys_ratio_nonzero: assert property (state.sys_sel >= pcd_pkg::SYS_MIN)
    else $error("system divide value zero");

  a_sys_write_now: assert property (bus.wr && bus.addr == pcd_pkg::ADDR_DIV
    && bus.wdata[pcd_pkg::DIV_SYS_MSB:pcd_pkg::DIV_SYS_LSB] >= pcd_pkg::SYS_MIN
    |=> state.sys_sel == $past(bus.wdata[pcd_pkg::DIV_SYS_MSB:pcd_pkg::DIV_SYS_LSB]))
    else $error("system select write not applied at once");

  a_core_decode: assert property (state.fsm == pcd_pkg::ST_RUN && !state.bypass
    |-> core_ratio == (state.core_sel == 2'h0 ? 4'h1 : state.core_sel == 2'h1 ? 4'h2
                       : state.core_sel == 2'h2 ? 4'h4 : 4'h8))
    else $error("core ratio decode wrong");

  a_periph_sys: assert property (PERIPH_CLK_EN == SYS_CLK_EN)
    else $error("peripheral enable not from system clock");

  a_settle_bound: assert property (s_relock_start |-> s_relock_end)
    else $error("pll did not settle in time");

  a_bypass_full: assert property (state.bypass |=> SYS_CLK_EN && CORE_CLK_EN)
    else $error("bypass does not run at input rate");

  a_bypass_hold: assert property (state.bypass |=> $stable(PLL_MULT))
    else $error("multiplier applied while bypassed");

  a_lock_gate: assert property (lock_busy |-> !LOCKED && src_tick)
    else $error("pll used before lock count ended");

  a_lock_load: assert property (state.start |=> lock_busy || $past(state.lock_count) == 16'h0000)
    else $error("lock counter not loaded");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the clock control block: registers, dividers, relock and bypass
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK;
  logic        RST_N;
  logic [3:0]  ADDR;
  logic [31:0] WDATA;
  logic        WR;
  logic        RD;
  logic [31:0] RDATA;
  logic        VCO_TICK;
  logic        CORE_CLK_EN;
  logic        SYS_CLK_EN;
  logic        PERIPH_CLK_EN;
  logic [7:0]  PLL_MULT;
  logic        PLL_BYPASS;
  logic        VOLT_CHANGE;
  logic        LOCKED;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic        rd_d;
  int          mismatches;
  int          num_checks;
  int          cycles;
  int          lk;
  logic [3:0]  sys;
  logic [7:0]  m;
  logic [7:0]  m2;

  pcd_clock_control u_pcd_clock_control (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .VCO_TICK(VCO_TICK), .CORE_CLK_EN(CORE_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .PLL_MULT(PLL_MULT), .PLL_BYPASS(PLL_BYPASS),
    .VOLT_CHANGE(VOLT_CHANGE), .LOCKED(LOCKED)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 100 ns clock; the pll tick toggles every cycle, so one tick per two cycles
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // the input clock and the pll tick run without pause for the whole run
  always @(posedge CLK) VCO_TICK <= ~VCO_TICK;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus master tasks; a read leaves its expectation in the queue for the monitor
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] msk);
    exp_q.push_back(e);
    mask_q.push_back(msk);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so they are looked at there
  always @(posedge CLK) rd_d <= RD;

  always @(negedge CLK)
  begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
      check("rdata", RDATA & mask_q.pop_front(), exp_q.pop_front());
    check("periph_en", 32'(PERIPH_CLK_EN), 32'(SYS_CLK_EN));
  end

  // hang guard: the whole sequence needs only a few thousand cycles
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulse spacing of one enable, skipping the first two intervals after a change
  task automatic period(input logic core, input int exp);
    int n;
    int k;
    for (k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge CLK);
        n++;
      end
      while ((core ? CORE_CLK_EN : SYS_CLK_EN) !== 1'b1 && n < 100);
    end
    check(core ? "core_period" : "sys_period", n, exp);
  endtask

  // relock: locked falls, the system enable runs at input rate, locked returns after the count
  task automatic relock(input int load, input logic [7:0] mult, input logic volt);
    int n;
    int eff;
    logic seen_v;
    eff = (load > 400) ? 400 : load;
    seen_v = 1'b0;
    n = 0;
    while (LOCKED !== 1'b0 && n < 5)
    begin
      @(negedge CLK);
      seen_v |= (VOLT_CHANGE === 1'b1);
      n++;
    end
    check("lock_fall", 32'(LOCKED), 32'h0);
    check("pll_mult", 32'(PLL_MULT), 32'(mult));
    n = 0;
    while (LOCKED !== 1'b1 && n < 500)
    begin
      @(negedge CLK);
      seen_v |= (VOLT_CHANGE === 1'b1);
      if (n == 3)
        check("relock_sys", 32'(SYS_CLK_EN), 32'h1);
      n++;
    end
    check("lock_len", 32'(n >= eff && n <= eff + 4), 32'h1);
    check("volt_pulse", 32'(seen_v), 32'(volt));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    RST_N = 1'b0;
    ADDR = 4'h0;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    VCO_TICK = 1'b0;
    void'($urandom(32'h5911AD72));
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    rd(pcd_pkg::ADDR_CTL, 32'h14, 32'h1FF);
    rd(pcd_pkg::ADDR_DIV, 32'h05, 32'h3F);
    rd(pcd_pkg::ADDR_LOCK, 32'h200, 32'hFFFF);
    rd(pcd_pkg::ADDR_STATUS, 32'h1401, 32'hFF03);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    period(1'b0, 10);
    // every core select code with a random system divide
    for (int i = 0; i < 4; i++)
    begin
      sys = 4'($urandom_range(15, 1));
      wr(pcd_pkg::ADDR_DIV, {26'h0, 2'(i), sys});
      period(1'b0, 2 * sys);
      period(1'b1, 2 << i);
    end
    // a zero system divide is refused, core select still taken
    wr(pcd_pkg::ADDR_DIV, 32'h20);
    rd(pcd_pkg::ADDR_DIV, {26'h0, 2'h2, sys}, 32'h3F);
    lk = $urandom_range(40, 5);
    wr(pcd_pkg::ADDR_LOCK, 32'(lk));
    rd(pcd_pkg::ADDR_LOCK, 32'(lk), 32'hFFFF);
    m = 8'($urandom_range(128, 1));
    if (m == 8'h14)
      m = 8'h15;
    wr(pcd_pkg::ADDR_CTL, 32'(m));
    relock(lk, m, 1'b0);
    rd(pcd_pkg::ADDR_STATUS, {16'h0, m, 8'h01}, 32'hFF03);
    // out-of-range multipliers leave the applied one alone
    wr(pcd_pkg::ADDR_CTL, 32'h0);
    wr(pcd_pkg::ADDR_CTL, 32'h81);
    repeat (5) @(posedge CLK);
    check("mult_kept", 32'(PLL_MULT), 32'(m));
    check("no_relock", 32'(LOCKED), 32'h1);
    wr(pcd_pkg::ADDR_CTL, 32'h200 | 32'(m));
    relock(lk, m, 1'b1);
    // a huge lock count is capped at the settle limit
    m2 = (m == 8'h80) ? 8'h7F : 8'h80;
    wr(pcd_pkg::ADDR_LOCK, 32'hFFFF);
    wr(pcd_pkg::ADDR_CTL, 32'(m2));
    relock(65535, m2, 1'b0);
    // bypass holds the new multiplier and runs both clocks at input rate
    wr(pcd_pkg::ADDR_LOCK, 32'(lk));
    wr(pcd_pkg::ADDR_CTL, 32'h130);
    repeat (4) @(posedge CLK);
    check("bypass", 32'(PLL_BYPASS), 32'h1);
    check("mult_held", 32'(PLL_MULT), 32'(m2));
    check("bypass_lock", 32'(LOCKED), 32'h1);
    period(1'b0, 1);
    period(1'b1, 1);
    wr(pcd_pkg::ADDR_CTL, 32'h30);
    relock(lk, 8'h30, 1'b0);
    period(1'b0, 2 * sys);
    // reset in mid-run restores the default multiplier
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(pcd_pkg::ADDR_CTL, 32'h14, 32'h1FF);
    repeat (4) @(posedge CLK);
    check("queue_empty", 32'(exp_q.size()), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
